// [core/csi_pkg.sv]
// csi_pkg: shared types and constants of the charge status indicator
// assumes a 50 MHz system clock and a temperature level digitised in millivolts
package csi_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned SLOW_HALF_MS = 500;
  localparam int unsigned FAST_HALF_MS = 50;
  localparam int unsigned SHORT_BEEP_MS = 100;
  localparam int unsigned LONG_BEEP_MS = 1000;
  localparam int unsigned SLOW_HALF_CYC = SLOW_HALF_MS * CYC_PER_MS;
  localparam int unsigned FAST_HALF_CYC = FAST_HALF_MS * CYC_PER_MS;
  localparam int unsigned SHORT_BEEP_CYC = SHORT_BEEP_MS * CYC_PER_MS;
  localparam int unsigned LONG_BEEP_CYC = LONG_BEEP_MS * CYC_PER_MS;
  localparam int unsigned TICK_W = 26;

  // double flash: index of the last fast half-period in a frame, and the two lit slots
  localparam logic [3:0] DBL_FRAME_LAST = 4'h9;
  localparam logic [3:0] DBL_SLOT_A = 4'h0;
  localparam logic [3:0] DBL_SLOT_B = 4'h2;

  // temperature thresholds in mV: 500, 2200, 3000, 3150
  localparam logic [11:0] TEMP_MIN_MV = 12'h01F4;
  localparam logic [11:0] TEMP_START_MAX_MV = 12'h0898;
  localparam logic [11:0] TEMP_LI_MAX_MV = 12'h0BB8;
  localparam logic [11:0] TEMP_NI_MAX_MV = 12'h0C4E;

  // reset values
  localparam logic [3:0] DBL_RST = 4'h0;
  localparam logic [TICK_W-1:0] TICK_RST = 26'h000_0000;

  typedef enum logic [3:0] {
    PH_NO_BATT = 4'h0,
    PH_NEW_TEST = 4'h1,
    PH_PRE = 4'h2,
    PH_FAST1 = 4'h3,
    PH_FAST2 = 4'h4,
    PH_MAINT = 4'h5,
    PH_DISCH = 4'h6,
    PH_TEMP_ERR = 4'h7,
    PH_GEN_ERR = 4'h8
  } csi_phase_e;

  typedef enum logic [2:0] {
    PAT_OFF = 3'h0,
    PAT_ON = 3'h1,
    PAT_SLOW = 3'h2,
    PAT_FAST = 3'h3,
    PAT_DBL = 3'h4
  } csi_pat_e;

  typedef enum logic [1:0] {
    BEEP_NONE = 2'h0,
    BEEP_SHORT = 2'h1,
    BEEP_LONG = 2'h2
  } csi_beep_e;

  typedef enum logic [1:0] {
    BZ_IDLE = 2'b00,
    BZ_SHORT = 2'b01,
    BZ_LONG = 2'b10
  } csi_bz_state_e;

  typedef struct packed {
    csi_pat_e led_a;
    csi_pat_e led_b;
    csi_pat_e led_c;
    csi_beep_e beep;
  } csi_ind_s;

endpackage

// [core/csi_tick_div.sv]
// csi_tick_div: free-running divider, one-cycle tick every PERIOD clocks
// assumes PERIOD of at least 2
`timescale 1ns/1ps
module csi_tick_div #(
  parameter int unsigned PERIOD = 16
) (
  input wire logic clk,
  input wire logic rst,
  output logic tick
);

  logic [csi_pkg::TICK_W-1:0] cnt;
  wire wrap = (cnt == csi_pkg::TICK_W'(PERIOD - 1));
  wire [csi_pkg::TICK_W-1:0] next_cnt = wrap ? csi_pkg::TICK_RST : cnt + 1'b1;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= csi_pkg::TICK_RST;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= wrap;
    end
  end

endmodule // csi_tick_div

// [core/csi_top.sv]
// csi_top: LED, buzzer and discharge indication plus temperature supervision
// assumes phase, chemistry and temperature inputs synchronous to CLK
`timescale 1ns/1ps
module csi_top #(
  parameter int unsigned SLOW_HALF_CYC = csi_pkg::SLOW_HALF_CYC,
  parameter int unsigned FAST_HALF_CYC = csi_pkg::FAST_HALF_CYC,
  parameter int unsigned SHORT_BEEP_CYC = csi_pkg::SHORT_BEEP_CYC,
  parameter int unsigned LONG_BEEP_CYC = csi_pkg::LONG_BEEP_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  input wire csi_pkg::csi_phase_e PHASE,
  input wire logic CHEM_LITHIUM,
  input wire logic CHARGING,
  input wire logic [11:0] TEMP_MV,
  output logic STATUS_LED_A,
  output logic STATUS_LED_B,
  output logic STATUS_LED_C,
  output logic BUZZER,
  output logic DISCHARGE,
  output logic CHARGE_PERMIT,
  output logic TEMP_FAULT,
  output logic CHARGE_ABORT
);

  // phase to indication table
  function automatic csi_pkg::csi_ind_s ind_of(input csi_pkg::csi_phase_e ph);
    csi_pkg::csi_ind_s r;
    r = '{csi_pkg::PAT_OFF, csi_pkg::PAT_OFF, csi_pkg::PAT_OFF, csi_pkg::BEEP_NONE};
    unique case (ph)
      csi_pkg::PH_NO_BATT: r = r;
      csi_pkg::PH_NEW_TEST: r = '{csi_pkg::PAT_FAST, csi_pkg::PAT_OFF, csi_pkg::PAT_OFF, csi_pkg::BEEP_SHORT};
      csi_pkg::PH_PRE: r = '{csi_pkg::PAT_SLOW, csi_pkg::PAT_OFF, csi_pkg::PAT_OFF, csi_pkg::BEEP_NONE};
      csi_pkg::PH_FAST1: r = '{csi_pkg::PAT_ON, csi_pkg::PAT_SLOW, csi_pkg::PAT_OFF, csi_pkg::BEEP_NONE};
      csi_pkg::PH_FAST2: r = '{csi_pkg::PAT_ON, csi_pkg::PAT_FAST, csi_pkg::PAT_OFF, csi_pkg::BEEP_NONE};
      csi_pkg::PH_MAINT: r = '{csi_pkg::PAT_ON, csi_pkg::PAT_OFF, csi_pkg::PAT_ON, csi_pkg::BEEP_LONG};
      csi_pkg::PH_DISCH: r = '{csi_pkg::PAT_OFF, csi_pkg::PAT_SLOW, csi_pkg::PAT_OFF, csi_pkg::BEEP_NONE};
      csi_pkg::PH_TEMP_ERR: r = '{csi_pkg::PAT_DBL, csi_pkg::PAT_OFF, csi_pkg::PAT_ON, csi_pkg::BEEP_SHORT};
      csi_pkg::PH_GEN_ERR: r = '{csi_pkg::PAT_FAST, csi_pkg::PAT_OFF, csi_pkg::PAT_FAST, csi_pkg::BEEP_SHORT};
      default: r = r;
    endcase
    return r;
  endfunction

  // flash time base
  logic slow_tick;
  logic fast_tick;
  logic slow_lvl;
  logic fast_lvl;
  logic [3:0] dbl_cnt;

  csi_tick_div #(.PERIOD(SLOW_HALF_CYC)) u_slow_div (
    .clk(CLK),
    .rst(RST),
    .tick(slow_tick)
  );

  csi_tick_div #(.PERIOD(FAST_HALF_CYC)) u_fast_div (
    .clk(CLK),
    .rst(RST),
    .tick(fast_tick)
  );

  wire dbl_wrap = (dbl_cnt == csi_pkg::DBL_FRAME_LAST);
  wire [3:0] next_dbl_cnt = !fast_tick ? dbl_cnt : (dbl_wrap ? csi_pkg::DBL_RST : dbl_cnt + 4'h1);
  wire dbl_lvl = (dbl_cnt == csi_pkg::DBL_SLOT_A) || (dbl_cnt == csi_pkg::DBL_SLOT_B);

  always_ff @(posedge CLK) begin
    if (RST) begin
      slow_lvl <= 1'b0;
      fast_lvl <= 1'b0;
      dbl_cnt <= csi_pkg::DBL_RST;
    end else begin
      slow_lvl <= slow_lvl ^ slow_tick;
      fast_lvl <= fast_lvl ^ fast_tick;
      dbl_cnt <= next_dbl_cnt;
    end
  end

  // pattern selection
  csi_pkg::csi_ind_s ind;
  assign ind = ind_of(PHASE);

  function automatic logic pat_lvl(input csi_pkg::csi_pat_e p, input logic s, input logic f, input logic d);
    logic v;
    v = 1'b0;
    unique case (p)
      csi_pkg::PAT_OFF: v = 1'b0;
      csi_pkg::PAT_ON: v = 1'b1;
      csi_pkg::PAT_SLOW: v = s;
      csi_pkg::PAT_FAST: v = f;
      csi_pkg::PAT_DBL: v = d;
      default: v = 1'b0;
    endcase
    return v;
  endfunction

  wire next_led_a = pat_lvl(ind.led_a, slow_lvl, fast_lvl, dbl_lvl);
  wire next_led_b = pat_lvl(ind.led_b, slow_lvl, fast_lvl, dbl_lvl);
  wire next_led_c = pat_lvl(ind.led_c, slow_lvl, fast_lvl, dbl_lvl);
  wire next_discharge = (PHASE == csi_pkg::PH_DISCH);

  // buzzer: one beep per entry into a phase that has a beep
  csi_pkg::csi_phase_e prev_phase;
  csi_pkg::csi_bz_state_e bz_state;
  csi_pkg::csi_bz_state_e next_bz_state;
  logic [csi_pkg::TICK_W-1:0] bz_cnt;

  wire phase_entry = (PHASE != prev_phase);
  wire want_short = phase_entry && (ind.beep == csi_pkg::BEEP_SHORT);
  wire want_long = phase_entry && (ind.beep == csi_pkg::BEEP_LONG);
  wire short_done = (bz_cnt == csi_pkg::TICK_W'(SHORT_BEEP_CYC - 1));
  wire long_done = (bz_cnt == csi_pkg::TICK_W'(LONG_BEEP_CYC - 1));

  always_comb begin
    next_bz_state = bz_state;
    if (want_short) begin
      next_bz_state = csi_pkg::BZ_SHORT;
    end else if (want_long) begin
      next_bz_state = csi_pkg::BZ_LONG;
    end else begin
      unique case (bz_state)
        csi_pkg::BZ_IDLE: next_bz_state = csi_pkg::BZ_IDLE;
        csi_pkg::BZ_SHORT: next_bz_state = short_done ? csi_pkg::BZ_IDLE : csi_pkg::BZ_SHORT;
        csi_pkg::BZ_LONG: next_bz_state = long_done ? csi_pkg::BZ_IDLE : csi_pkg::BZ_LONG;
        default: next_bz_state = csi_pkg::BZ_IDLE;
      endcase
    end
  end

  wire bz_restart = want_short || want_long;
  wire [csi_pkg::TICK_W-1:0] next_bz_cnt = bz_restart ? csi_pkg::TICK_RST : bz_cnt + 1'b1;
  wire next_buzzer = (next_bz_state != csi_pkg::BZ_IDLE);

  // temperature supervision
  wire temp_low = (TEMP_MV < csi_pkg::TEMP_MIN_MV);
  wire start_ok = !temp_low && (TEMP_MV <= csi_pkg::TEMP_START_MAX_MV);
  wire temp_high = CHEM_LITHIUM ? (TEMP_MV > csi_pkg::TEMP_LI_MAX_MV) : (TEMP_MV > csi_pkg::TEMP_NI_MAX_MV);
  wire fault_now = CHARGING && (temp_low || temp_high);
  wire next_fault = fault_now || (TEMP_FAULT && CHARGING);

  always_ff @(posedge CLK) begin
    if (RST) begin
      prev_phase <= csi_pkg::PH_NO_BATT;
      bz_state <= csi_pkg::BZ_IDLE;
      bz_cnt <= csi_pkg::TICK_RST;
    end else begin
      prev_phase <= PHASE;
      bz_state <= next_bz_state;
      bz_cnt <= next_bz_cnt;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      STATUS_LED_A <= 1'b0;
      STATUS_LED_B <= 1'b0;
      STATUS_LED_C <= 1'b0;
      BUZZER <= 1'b0;
      DISCHARGE <= 1'b0;
      CHARGE_PERMIT <= 1'b0;
      TEMP_FAULT <= 1'b0;
      CHARGE_ABORT <= 1'b0;
    end else begin
      STATUS_LED_A <= next_led_a;
      STATUS_LED_B <= next_led_b;
      STATUS_LED_C <= next_led_c;
      BUZZER <= next_buzzer;
      DISCHARGE <= next_discharge;
      CHARGE_PERMIT <= start_ok && !fault_now;
      TEMP_FAULT <= next_fault;
      CHARGE_ABORT <= fault_now && !TEMP_FAULT;
    end
  end

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  logic [csi_pkg::TICK_W-1:0] bz_high_cnt;
  always_ff @(posedge CLK) begin
    if (RST) begin
      bz_high_cnt <= csi_pkg::TICK_RST;
    end else begin
      // a restart begins a new beep, so the length count starts again
      bz_high_cnt <= (BUZZER && !bz_restart) ? bz_high_cnt + 1'b1 : csi_pkg::TICK_RST;
    end
  end

  sequence s_quiet_entry;
    !BUZZER && phase_entry && ind.beep != csi_pkg::BEEP_NONE;
  endsequence

  sequence s_beep_rise;
    !BUZZER ##1 BUZZER;
  endsequence

  a_led_maint_map: assert property ((PHASE == csi_pkg::PH_MAINT) |=> STATUS_LED_A && !STATUS_LED_B && STATUS_LED_C)
    else $error("maintenance LED pattern wrong");
  a_led_nobatt_off: assert property ((PHASE == csi_pkg::PH_NO_BATT) |=> !STATUS_LED_A && !STATUS_LED_B && !STATUS_LED_C)
    else $error("no battery LEDs not off");
  a_led_slow_follow: assert property ((ind.led_b == csi_pkg::PAT_SLOW) |=> STATUS_LED_B == $past(slow_lvl))
    else $error("slow flash level mismatch");
  a_beep_on_entry: assert property (s_quiet_entry |=> BUZZER)
    else $error("beep missing on phase entry");
  a_beep_max_len: assert property (bz_high_cnt <= csi_pkg::TICK_W'(LONG_BEEP_CYC))
    else $error("beep longer than long beep");
  a_buzz_steady_level: assert property (s_beep_rise |-> BUZZER [*8])
    else $error("buzzer toggling inside beep");
  a_beep_no_repeat: assert property ($fell(BUZZER) && !phase_entry |=> !BUZZER)
    else $error("beep repeated without phase entry");
  a_discharge_only: assert property (DISCHARGE |-> $past(PHASE) == csi_pkg::PH_DISCH)
    else $error("discharge outside discharge phase");
  a_start_window: assert property (CHARGE_PERMIT |-> $past(TEMP_MV) >= csi_pkg::TEMP_MIN_MV
      && $past(TEMP_MV) <= csi_pkg::TEMP_START_MAX_MV)
    else $error("charge permitted outside start window");
  a_fault_abort: assert property (fault_now && !TEMP_FAULT |=> TEMP_FAULT && CHARGE_ABORT ##1 !CHARGE_ABORT)
    else $error("temperature fault not flagged");

endmodule // csi_top

// [verification/csi_far_model.sv]
// csi_far_model: thermistor divider and end-of-charge gate beside the block
// assumes levels in millivolts and active-high led drive
`timescale 1ns/1ps
module csi_far_model #(
  parameter logic [11:0] NO_NTC_MV = 12'h04B0
) (
  input wire logic ntc_fitted,
  input wire logic [11:0] ntc_mv,
  input wire logic led_a,
  input wire logic led_c,
  output logic [11:0] temp_mv,
  output logic end_of_charge_n
);
  assign temp_mv = ntc_fitted ? ntc_mv : NO_NTC_MV;
  assign end_of_charge_n = ~(led_a & led_c);
endmodule // csi_far_model

// [verification/charge_status_indicator_tb.sv]
// charge_status_indicator_tb: scenario tasks for csi_top with short timing
// assumes csi_pkg compiled first, 50 MHz clock
`timescale 1ns/1ps
module charge_status_indicator_tb;
  localparam int S = 20;
  localparam int F = 4;
  localparam int SB = 16;
  localparam int LB = 40;
  logic clk = 1'b0;
  logic rst = 1'b1;
  csi_pkg::csi_phase_e phase = csi_pkg::PH_NO_BATT;
  logic li = 1'b0;
  logic chg = 1'b0;
  logic fit = 1'b1;
  logic [11:0] ntc = 12'h04B0;
  logic [11:0] temp;
  logic eoc_n, led_a, led_b, led_c, buzz, dis, permit, fault, abort_p;
  int fail_count = 0;
  int checked = 0;
  int cyc = 0;
  always #10 clk = ~clk;
  csi_far_model far_u (.ntc_fitted(fit), .ntc_mv(ntc), .led_a(led_a), .led_c(led_c), .temp_mv(temp),
    .end_of_charge_n(eoc_n));
  csi_top #(.SLOW_HALF_CYC(S), .FAST_HALF_CYC(F), .SHORT_BEEP_CYC(SB), .LONG_BEEP_CYC(LB)) dut_u (
    .CLK(clk), .RST(rst), .PHASE(phase), .CHEM_LITHIUM(li), .CHARGING(chg), .TEMP_MV(temp),
    .STATUS_LED_A(led_a), .STATUS_LED_B(led_b), .STATUS_LED_C(led_c), .BUZZER(buzz),
    .DISCHARGE(dis), .CHARGE_PERMIT(permit), .TEMP_FAULT(fault), .CHARGE_ABORT(abort_p));
  task stop_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  function logic pick(input int s);
    return s == 0 ? led_a : (s == 1 ? led_b : led_c);
  endfunction
  task set_ph(input csi_pkg::csi_phase_e p);
    @(posedge clk);
    phase <= p;
    repeat (3) @(negedge clk);
  endtask
  // measures one full half period of a flashing led
  task half(input int s, input int exp);
    int n;
    logic v;
    n = 0;
    v = pick(s);
    while (pick(s) === v && n < 60) begin
      @(negedge clk);
      n++;
    end
    v = pick(s);
    n = 0;
    while (pick(s) === v && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk(n, exp);
  endtask
  task t_leds;
    int n;
    set_ph(csi_pkg::PH_PRE);
    half(0, S);
    chk({led_b, led_c, dis}, 3'b000);
    set_ph(csi_pkg::PH_FAST1);
    half(1, S);
    chk({led_a, led_c}, 2'b10);
    @(posedge clk);
    li <= 1'b1;
    set_ph(csi_pkg::PH_FAST2);
    half(1, F);
    chk({led_a, led_c}, 2'b10);
    set_ph(csi_pkg::PH_MAINT);
    chk({led_a, led_b, led_c, eoc_n}, 4'b1010);
    set_ph(csi_pkg::PH_GEN_ERR);
    half(0, F);
    half(2, F);
    set_ph(csi_pkg::PH_NEW_TEST);
    half(0, F);
    chk({led_b, led_c}, 2'b00);
    set_ph(csi_pkg::PH_TEMP_ERR);
    n = 0;
    repeat (20 * F) begin
      @(negedge clk);
      if (led_a === 1'b1) n++;
      chk({led_b, led_c}, 2'b01);
    end
    chk(n, 4 * F);
    @(posedge clk);
    li <= 1'b0;
    set_ph(csi_pkg::PH_DISCH);
    half(1, S);
    chk({led_a, led_c, dis}, 3'b001);
    set_ph(csi_pkg::csi_phase_e'(4'hF));
    chk({led_a, led_b, led_c, buzz, dis}, 5'b00000);
    set_ph(csi_pkg::PH_NO_BATT);
    chk({led_a, led_b, led_c, dis, eoc_n}, 5'b00001);
    $display("done leds");
  endtask
  // counts beep cycles and buzzer edges over a window after entry
  task beep(input csi_pkg::csi_phase_e p, input int len);
    int n;
    int t;
    logic last;
    n = 0;
    t = 0;
    last = buzz;
    @(posedge clk);
    phase <= p;
    repeat (100) begin
      @(negedge clk);
      if (buzz === 1'b1) n++;
      if (buzz !== last) t++;
      last = buzz;
    end
    chk(n, len);
    chk(t, len > 0 ? 2 : 0);
    $display("done beep");
  endtask
  task tmp(input logic l, input logic c, input logic [11:0] mv, input logic pe, input logic fe);
    @(posedge clk);
    li <= l;
    chg <= c;
    ntc <= mv;
    repeat (2) @(negedge clk);
    chk(permit, pe);
    chk({fault, abort_p}, {fe, fe});
    @(negedge clk);
    chk({fault, abort_p}, {fe, 1'b0});
    @(posedge clk);
    chg <= 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task t_temp;
    tmp(1'b0, 1'b0, 12'h01F4, 1'b1, 1'b0);
    tmp(1'b0, 1'b0, 12'h0898, 1'b1, 1'b0);
    tmp(1'b0, 1'b0, 12'h01F3, 1'b0, 1'b0);
    tmp(1'b0, 1'b0, 12'h0899, 1'b0, 1'b0);
    tmp(1'b1, 1'b1, 12'h0BB9, 1'b0, 1'b1);
    tmp(1'b1, 1'b1, 12'h0BB8, 1'b0, 1'b0);
    tmp(1'b0, 1'b1, 12'h0BB9, 1'b0, 1'b0);
    tmp(1'b0, 1'b1, 12'h0C4F, 1'b0, 1'b1);
    tmp(1'b0, 1'b1, 12'h0C4E, 1'b0, 1'b0);
    tmp(1'b1, 1'b1, 12'h01F3, 1'b0, 1'b1);
    @(posedge clk);
    fit <= 1'b0;
    tmp(1'b0, 1'b0, 12'h0000, 1'b1, 1'b0);
    $display("done temp");
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_leds();
    beep(csi_pkg::PH_NEW_TEST, SB);
    beep(csi_pkg::PH_MAINT, LB);
    beep(csi_pkg::PH_FAST1, 0);
    beep(csi_pkg::PH_TEMP_ERR, SB);
    t_temp();
    stop_test();
  end
endmodule // charge_status_indicator_tb
